// >>> osc_device.sv
// Configuration store end: OTP array, volatile shadows, write lock, serial slave
// Behaviour
// - OTP bits only go from zero to one
// - Host never programs a set bit twice
// - Power-on copies OTP into shadow registers
// - Start locked except 00-03, 10-12, 1B
// - Key AB at 10 unlocks writes
// - Unlocked writes persist until power-off
// - Any other byte at 10 relocks
// - Programming only through command addresses
// - Shadow writes never reach OTP automatically
// - Shadows occupy 00 to 0D, bytes
// - Zero position low 02, high 03
// - Bit 7 of 04 selects commutation output
// - Bits 4:3 of 04 set index width
// - Bits 2:0 of 04 set pole pairs
// - Host keeps serial clock within maximum rate
// - Host waits prepare time before clocking
// - Host leaves idle gap between requests
`timescale 1ns/1ps
`default_nettype none
module osc_device
  import osc_pkg::*;
(
  // Clock and reset (reset stands for power-on)
  input wire logic aclk,
  input wire logic aresetn,
  // Serial link
  osc_link_if.device link,
  // Blanks the OTP array, for a fresh part in simulation
  input wire logic otp_blank,
  // Configuration outputs
  output logic [15:0] zero_position,
  output logic commutation_output_choice,
  output logic [8:0] index_width_deg,
  output logic [3:0] pole_pairs,
  // Status
  output logic unlocked,
  output logic shadow_ready,
  output logic burn_pulse
);
  logic [2:0] pins_s;
  logic cs_n_s;
  logic sclk_s;
  logic mosi_s;
  logic sclk_prev_reg;
  logic rise;
  logic fall;
  logic [4:0] bit_cnt_reg;
  logic [15:0] rx_reg;
  logic [15:0] rx_next;
  logic [7:0] tx_reg;
  logic miso_reg;
  logic miso_oe_reg;
  logic wr_en;
  logic wr_ok;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic burn;
  logic unlocked_reg;
  logic load_pending_reg;
  logic [7:0] shadow_reg [OSC_SHADOW_N];
  logic [7:0] otp_reg [OSC_SHADOW_N];
  logic [OSC_SHADOW_N-1:0] burn_mask;

  // Pins come from the host's domain; the first stage is read only by the second
  osc_sync2 #(.W(3), .RST(3'h4)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({link.cs_n, link.sclk, link.mosi}),
    .q(pins_s)
  );
  assign cs_n_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign mosi_s = pins_s[0];
  assign rise = !cs_n_s && sclk_s && !sclk_prev_reg;
  assign fall = !cs_n_s && !sclk_s && sclk_prev_reg;
  assign rx_next = {rx_reg[14:0], mosi_s};

  // Always-open addresses stay writable while locked
  function automatic logic always_open(input logic [6:0] a);
    always_open = (a <= ADDR_ZERO_HI) || (a >= ADDR_LOCK && a <= ADDR_BURN_ZERO) || (a == ADDR_CMD_EXTRA);
  endfunction

  function automatic logic [7:0] read_byte(input logic [6:0] a);
    if (a <= ADDR_SHADOW_LAST) begin
      read_byte = shadow_reg[a[3:0]];
    end else if (a == ADDR_LOCK) begin
      read_byte = {7'h00, unlocked_reg};
    end else begin
      read_byte = 8'h00;
    end
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= sclk_s;
    end
  end

  // Frame receiver; a frame ends, complete or not, when select rises
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_cnt_reg <= 5'h00;
      rx_reg <= 16'h0000;
    end else if (cs_n_s) begin
      bit_cnt_reg <= 5'h00;
    end else if (rise && bit_cnt_reg < 5'(OSC_FRAME_BITS)) begin
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
      rx_reg <= rx_next;
    end
  end

  // Read data is fetched once the header is in and shifted out on falling edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_reg <= 8'h00;
      miso_reg <= 1'b0;
      miso_oe_reg <= 1'b0;
    end else begin
      // Drive enable covers only the data half of a read frame
      if (cs_n_s) begin
        miso_oe_reg <= 1'b0;
      end else if (rise && bit_cnt_reg == 5'(OSC_HDR_BITS - 1) && rx_next[7]) begin
        miso_oe_reg <= 1'b1;
      end
      if (rise && bit_cnt_reg == 5'(OSC_HDR_BITS - 1)) begin
        tx_reg <= rx_next[7] ? read_byte(rx_next[6:0]) : 8'h00;
      end else if (fall && bit_cnt_reg >= 5'(OSC_HDR_BITS)) begin
        miso_reg <= tx_reg[7];
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
    end
  end
  assign link.miso = miso_reg;
  assign link.miso_oe = miso_oe_reg;

  assign wr_en = rise && bit_cnt_reg == 5'(OSC_FRAME_BITS - 1) && !rx_next[15];
  assign wr_addr = rx_next[14:8];
  assign wr_data = rx_next[7:0];
  assign wr_ok = wr_en && (unlocked_reg || always_open(wr_addr));

  // Lock gate: power-on locks, the key unlocks, any other byte relocks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unlocked_reg <= 1'b0;
    end else if (wr_en && wr_addr == ADDR_LOCK) begin
      unlocked_reg <= (wr_data == UNLOCK_KEY);
    end
  end
  assign unlocked = unlocked_reg;

  // Shadows clear at power-on, then take the OTP copy one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_pending_reg <= 1'b1;
      for (int i = 0; i < OSC_SHADOW_N; i++) begin
        shadow_reg[i] <= SHADOW_RST;
      end
    end else if (load_pending_reg) begin
      load_pending_reg <= 1'b0;
      for (int i = 0; i < OSC_SHADOW_N; i++) begin
        shadow_reg[i] <= otp_reg[i];
      end
    end else if (wr_ok && wr_addr <= ADDR_SHADOW_LAST) begin
      shadow_reg[wr_addr[3:0]] <= wr_data;
    end
  end
  assign shadow_ready = !load_pending_reg;

  // Burn commands; 0x13, 0x14 and 0x1B are taken but program nothing here
  assign burn = wr_ok && wr_data == BURN_KEY && ((wr_addr >= ADDR_BURN_ALL && wr_addr <= ADDR_CMD_LAST)
                || wr_addr == ADDR_CMD_EXTRA);
  always_comb begin
    burn_mask = '0;
    if (wr_addr == ADDR_BURN_ALL) begin
      burn_mask = '1;
    end else if (wr_addr == ADDR_BURN_ZERO) begin
      burn_mask[ADDR_ZERO_LO[3:0]] = 1'b1;
      burn_mask[ADDR_ZERO_HI[3:0]] = 1'b1;
    end
  end

  // The array has no reset: it must survive power cycles
  always_ff @(posedge aclk) begin
    for (int i = 0; i < OSC_SHADOW_N; i++) begin
      if (otp_blank) begin
        otp_reg[i] <= 8'h00;
      end else if (burn && burn_mask[i]) begin
        otp_reg[i] <= otp_reg[i] | shadow_reg[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      burn_pulse <= 1'b0;
    end else begin
      burn_pulse <= burn;
    end
  end

  // Decoded configuration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      zero_position <= 16'h0000;
      commutation_output_choice <= 1'b0;
      index_width_deg <= IW_STEP_DEG;
      pole_pairs <= 4'h3;
    end else begin
      zero_position <= {shadow_reg[ADDR_ZERO_HI[3:0]], shadow_reg[ADDR_ZERO_LO[3:0]]};
      commutation_output_choice <= shadow_reg[ADDR_OUT_CFG[3:0]][CFG_CHOICE_BIT];
      index_width_deg <= IW_STEP_DEG * (9'(shadow_reg[ADDR_OUT_CFG[3:0]][CFG_IW_MSB:CFG_IW_LSB]) + 9'h001);
      case (shadow_reg[ADDR_OUT_CFG[3:0]][CFG_PP_MSB:0])
        3'h6: pole_pairs <= 4'h1;
        3'h7: pole_pairs <= 4'h2;
        default: pole_pairs <= {1'b0, shadow_reg[ADDR_OUT_CFG[3:0]][CFG_PP_MSB:0]} + 4'h3;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> osc_pkg.sv
// Shared constants for the configuration-store serial link and both of its ends
package osc_pkg;
  // Serial frame: bit 15 read flag, bits 14:8 address, bits 7:0 data
  localparam int OSC_FRAME_BITS = 16;
  localparam int OSC_HDR_BITS = 8;
  localparam int OSC_SHADOW_N = 14;
  // Device address map
  localparam logic [6:0] ADDR_SPARE0 = 7'h00;
  localparam logic [6:0] ADDR_SPARE1 = 7'h01;
  localparam logic [6:0] ADDR_ZERO_LO = 7'h02;
  localparam logic [6:0] ADDR_ZERO_HI = 7'h03;
  localparam logic [6:0] ADDR_OUT_CFG = 7'h04;
  localparam logic [6:0] ADDR_SHADOW_LAST = 7'h0D;
  localparam logic [6:0] ADDR_LOCK = 7'h10;
  localparam logic [6:0] ADDR_BURN_ALL = 7'h11;
  localparam logic [6:0] ADDR_BURN_ZERO = 7'h12;
  localparam logic [6:0] ADDR_CMD_LAST = 7'h14;
  localparam logic [6:0] ADDR_CMD_EXTRA = 7'h1B;
  localparam logic [7:0] UNLOCK_KEY = 8'hAB;
  localparam logic [7:0] BURN_KEY = 8'hA2;
  localparam logic [7:0] SHADOW_RST = 8'h00;
  // Fields of output_config_zero
  localparam int CFG_CHOICE_BIT = 7;
  localparam int CFG_IW_MSB = 4;
  localparam int CFG_IW_LSB = 3;
  localparam int CFG_PP_MSB = 2;
  localparam logic [8:0] IW_STEP_DEG = 9'h05A;
  // Timing at the 250 MHz system clock
  localparam int CLK_PERIOD_NS = 4;
  localparam int SCLK_MAX_KHZ = 10000;
  localparam int SSI_PREPARE_TIME_NS = 300;
  localparam int SSI_REQUEST_GAP_NS = 200;
  localparam int SCLK_MIN_HALF_CYC = ((1000000 / SCLK_MAX_KHZ) / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PREP_CYC = (SSI_PREPARE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYC = (SSI_REQUEST_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_HALF_DEFAULT = 20;
  // Host controller registers on AXI4-Lite
  localparam logic [3:0] HOST_CMD_OFS = 4'h0;
  localparam logic [3:0] HOST_STAT_OFS = 4'h4;
  localparam int CMD_READ_BIT = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> osc_link_if.sv
// Serial configuration link between host controller and configuration store
`timescale 1ns/1ps
`default_nettype none
interface osc_link_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  logic miso_oe;
  modport device (input cs_n, input sclk, input mosi, output miso, output miso_oe);
  modport host (output cs_n, output sclk, output mosi, input miso, input miso_oe);
endinterface
`default_nettype wire

// >>> osc_sync2.sv
// Two-flop synchroniser for inputs arriving from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module osc_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= RST;
      q <= RST;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// >>> osc_host.sv
// Host controller end: AXI4-Lite command registers driving the serial link
`timescale 1ns/1ps
`default_nettype none
module osc_host
  import osc_pkg::*;
#(
  parameter int SCLK_HALF = SCLK_HALF_DEFAULT
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial link
  osc_link_if.host link
);
  typedef enum logic [1:0] {ST_IDLE, ST_PREP, ST_SHIFT, ST_GAP} osc_state_t;

  // The half-period counter is 16 bits wide, and the rate must stay legal
  if (SCLK_HALF < SCLK_MIN_HALF_CYC || SCLK_HALF > 65536) begin : g_bad_half
    $error("SCLK_HALF out of range for the serial clock divider");
  end

  osc_state_t state_reg;
  logic [15:0] cnt_reg;
  logic [4:0] bit_cnt_reg;
  logic [15:0] tx_reg;
  logic [7:0] rx_reg;
  logic [7:0] rd_data_reg;
  logic cs_n_reg;
  logic sclk_reg;
  logic miso_s;
  logic start;
  logic wr_take;
  logic cmd_hit;

  osc_sync2 #(.W(1), .RST(1'b0)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(link.miso),
    .q(miso_s)
  );

  // Write path: address and data are taken together, one write at a time
  assign wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_take;
  assign s_axi_wready = wr_take;
  assign cmd_hit = s_axi_awaddr == HOST_CMD_OFS;
  assign start = wr_take && cmd_hit && state_reg == ST_IDLE && s_axi_wstrb[1:0] == 2'h3;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_take) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= start ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read path
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      if (s_axi_araddr == HOST_STAT_OFS) begin
        s_axi_rdata <= {16'h0000, rd_data_reg, 7'h00, state_reg != ST_IDLE};
      end else if (s_axi_araddr == HOST_CMD_OFS) begin
        s_axi_rdata <= {15'h0000, tx_reg[15], tx_reg};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Frame engine; the link clock is divided down from aclk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 16'h0000;
      bit_cnt_reg <= 5'h00;
      tx_reg <= 16'h0000;
      rx_reg <= 8'h00;
      rd_data_reg <= 8'h00;
      cs_n_reg <= 1'b1;
      sclk_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            tx_reg <= {s_axi_wdata[CMD_READ_BIT], s_axi_wdata[14:0]};
            cs_n_reg <= 1'b0;
            cnt_reg <= 16'h0000;
            bit_cnt_reg <= 5'h00;
            state_reg <= ST_PREP;
          end
        end
        ST_PREP: begin
          if (cnt_reg == 16'(PREP_CYC - 1)) begin
            cnt_reg <= 16'h0000;
            state_reg <= ST_SHIFT;
          end else begin
            cnt_reg <= cnt_reg + 16'h0001;
          end
        end
        ST_SHIFT: begin
          if (cnt_reg == 16'(SCLK_HALF - 1)) begin
            cnt_reg <= 16'h0000;
            sclk_reg <= !sclk_reg;
            if (!sclk_reg) begin
              rx_reg <= {rx_reg[6:0], miso_s};
              bit_cnt_reg <= bit_cnt_reg + 5'h01;
            end else if (bit_cnt_reg == 5'(OSC_FRAME_BITS)) begin
              cs_n_reg <= 1'b1;
              if (tx_reg[15]) begin
                rd_data_reg <= rx_reg;
              end
              state_reg <= ST_GAP;
            end else if (bit_cnt_reg != 5'h01) begin
              // The first fall only moves the wire from bit 15 to bit 14
              tx_reg <= {tx_reg[15], tx_reg[13:0], 1'b0};
            end
          end else begin
            cnt_reg <= cnt_reg + 16'h0001;
          end
        end
        ST_GAP: begin
          if (cnt_reg == 16'(GAP_CYC - 1)) begin
            state_reg <= ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg + 16'h0001;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Bit 15 of tx_reg keeps the read flag and stands until the first fall; bit 14 carries every later bit.
  // Data must not move at a rise, since the far end samples it there after the same synchroniser delay.
  assign link.cs_n = cs_n_reg;
  assign link.sclk = sclk_reg;
  assign link.mosi = (bit_cnt_reg == 5'h00 || (bit_cnt_reg == 5'h01 && sclk_reg)) ? tx_reg[15] : tx_reg[14];
endmodule
`default_nettype wire

// >>> osc_link_assertions.sv
// Wire-level checks on the serial configuration link
`timescale 1ns/1ps
`default_nettype none
module osc_link_assertions
  import osc_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link signals
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  logic [7:0] lo_cnt_reg;
  logic [7:0] hi_cnt_reg;
  logic [7:0] half_cnt_reg;
  logic [4:0] rise_cnt_reg;
  logic is_read_reg;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk) begin
    if (!aresetn || cs_n) lo_cnt_reg <= 8'h00;
    else if (lo_cnt_reg != 8'hFF) lo_cnt_reg <= lo_cnt_reg + 8'h01;
  end
  // Idle since power-on counts as a full gap
  always_ff @(posedge aclk) begin
    if (!aresetn) hi_cnt_reg <= 8'hFF;
    else if (!cs_n) hi_cnt_reg <= 8'h00;
    else if (hi_cnt_reg != 8'hFF) hi_cnt_reg <= hi_cnt_reg + 8'h01;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) half_cnt_reg <= 8'hFF;
    else if ($changed(sclk)) half_cnt_reg <= 8'h01;
    else if (half_cnt_reg != 8'hFF) half_cnt_reg <= half_cnt_reg + 8'h01;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || cs_n) rise_cnt_reg <= 5'h00;
    else if ($rose(sclk)) rise_cnt_reg <= rise_cnt_reg + 5'h01;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) is_read_reg <= 1'b0;
    else if (!cs_n && $rose(sclk) && rise_cnt_reg == 5'h00) is_read_reg <= mosi;
  end
  chk_prep_time: assert property ($rose(sclk) |-> lo_cnt_reg >= PREP_CYC)
    else $error("link clock started too soon");
  chk_request_gap: assert property ($fell(cs_n) |-> hi_cnt_reg >= GAP_CYC)
    else $error("frame gap too short");
  chk_half_period: assert property ($changed(sclk) |-> half_cnt_reg >= SCLK_MIN_HALF_CYC)
    else $error("link clock too fast");
  chk_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("link clock not low outside frame");
  chk_frame_bits: assert property ($rose(cs_n) |-> rise_cnt_reg == OSC_FRAME_BITS)
    else $error("wrong bit count in frame");
  chk_oe_read_only: assert property (miso_oe |-> is_read_reg)
    else $error("device drove data in a write frame");
  chk_oe_after_hdr: assert property ($rose(miso_oe) |-> rise_cnt_reg == OSC_HDR_BITS)
    else $error("device drove data at wrong bit");
  chk_oe_release: assert property ($rose(cs_n) |-> ##6 !miso_oe)
    else $error("device held data line after frame");
  chk_mosi_hold: assert property (!cs_n && sclk && $past(sclk) |-> $stable(mosi))
    else $error("host data moved while clock high");
  chk_miso_hold: assert property (miso_oe && sclk && $past(sclk) |-> $stable(miso))
    else $error("device data moved while clock high");
endmodule
`default_nettype wire

// >>> testbench.sv
// Bench joining host and device ends over the serial link
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import osc_pkg::*;
  logic aclk, aresetn, otp_blank, sclk_q;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [15:0] zero_position, frame_seen;
  logic [8:0] index_width_deg;
  logic [3:0] pole_pairs;
  logic commutation_output_choice, unlocked, burn_pulse, shadow_ready;
  logic [7:0] c;
  int fail_count, total_checks, i;
  int burns = 0;
  osc_link_if lk();
  osc_host i_osc_host (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .link(lk));
  osc_device i_osc_device (.aclk, .aresetn, .link(lk), .otp_blank, .zero_position,
    .commutation_output_choice, .index_width_deg, .pole_pairs, .unlocked, .shadow_ready, .burn_pulse);
  osc_link_assertions i_osc_link_assertions (.aclk, .aresetn, .cs_n(lk.cs_n), .sclk(lk.sclk),
    .mosi(lk.mosi), .miso(lk.miso), .miso_oe(lk.miso_oe));
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // Own view of the wire: last frame as shifted in at clock rises
  always @(posedge aclk) begin
    if (burn_pulse === 1'b1) burns <= burns + 1;
    if (!lk.cs_n && lk.sclk && !sclk_q) frame_seen <= {frame_seen[14:0], lk.mosi};
    sclk_q <= lk.sclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task stop_test;
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task timeout;
    fail_count++;
    $display("unexpected at %0t: no answer", $time);
    stop_test();
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 64) timeout();
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 64) timeout();
    r = s_axi_rresp;
    rd = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask
  task automatic idle;
    int n;
    for (n = 0; n < 999; n++) begin
      axi_rd(HOST_STAT_OFS);
      if (rd[0] === 1'b0) break;
    end
    if (n == 999) timeout();
  endtask
  // One device access; a read leaves the byte in rd[15:8]
  task automatic dev(input logic rw, input logic [6:0] a, input logic [7:0] d);
    axi_wr(HOST_CMD_OFS, {15'h0000, rw, 1'b0, a, d});
    chk(r, RESP_OKAY);
    idle();
  endtask
  task rst;
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    chk(shadow_ready, 1'b0);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(shadow_ready, 1'b1);
  endtask
  initial begin
    aresetn = 1'b0;
    otp_blank = 1'b1;
    s_axi_awaddr = 4'h0;
    s_axi_araddr = 4'h0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (2) @(posedge aclk);
    otp_blank <= 1'b0;
    rst();
    chk(zero_position, 16'h0000);
    chk(index_width_deg, 9'h05A);
    chk(pole_pairs, 4'h3);
    chk(commutation_output_choice, 1'b0);
    chk(unlocked, 1'b0);
    $display("test defaults done");
    dev(0, ADDR_OUT_CFG, 8'h9F);
    dev(1, ADDR_OUT_CFG, 8'h00);
    chk(rd[15:8], SHADOW_RST);
    dev(0, ADDR_SPARE1, 8'h5A);
    dev(0, ADDR_ZERO_LO, 8'hCD);
    dev(0, ADDR_ZERO_HI, 8'hAB);
    chk(frame_seen, 16'h03AB);
    chk({lk.cs_n, lk.sclk}, 2'b10);
    dev(1, ADDR_SPARE1, 8'h00);
    chk(rd[15:8], 8'h5A);
    chk(zero_position, 16'hABCD);
    dev(0, ADDR_SPARE0, BURN_KEY);
    chk(burns, 0);
    $display("test locked done");
    dev(0, ADDR_LOCK, UNLOCK_KEY);
    chk(unlocked, 1'b1);
    for (i = 0; i < 8; i++) begin
      c = {i[0], 2'b00, i[1:0], i[2:0]};
      dev(0, ADDR_OUT_CFG, c);
      dev(1, ADDR_OUT_CFG, 8'h00);
      chk(rd[15:8], c);
      chk(commutation_output_choice, i[0]);
      chk(index_width_deg, (i[1:0] == 2'b00) ? 9'h05A : (i[1:0] == 2'b01) ? 9'h0B4 : (i[1:0] == 2'b10) ? 9'h10E : 9'h168);
      chk(pole_pairs, (i < 6) ? i + 3 : i - 5);
    end
    $display("test unlocked done");
    dev(0, ADDR_LOCK, 8'hAA);
    chk(unlocked, 1'b0);
    dev(0, ADDR_OUT_CFG, 8'h00);
    dev(1, ADDR_OUT_CFG, 8'h00);
    chk(rd[15:8], 8'h9F);
    $display("test relock done");
    dev(0, ADDR_BURN_ZERO, BURN_KEY);
    chk(burns, 1);
    rst();
    chk(zero_position, 16'hABCD);
    chk(pole_pairs, 4'h3);
    dev(1, ADDR_SPARE1, 8'h00);
    chk(rd[15:8], 8'h00);
    // Second burn uses only bits still clear, so no bit is programmed twice
    dev(0, ADDR_ZERO_LO, 8'h32);
    dev(0, ADDR_ZERO_HI, 8'h00);
    dev(0, ADDR_BURN_ZERO, BURN_KEY);
    rst();
    chk(zero_position, 16'hABFF);
    $display("test burn done");
    axi_wr(HOST_CMD_OFS, 32'h0001_1000);
    axi_wr(HOST_CMD_OFS, 32'h0000_0000);
    chk(r, RESP_SLVERR);
    idle();
    chk(rd[15:8], 8'h00);
    axi_rd(4'h8);
    chk(r, RESP_SLVERR);
    chk(rd, 32'h0000_0000);
    axi_wr(4'hC, 32'h0000_0000);
    chk(r, RESP_SLVERR);
    $display("test host refusals done");
    stop_test();
  end
endmodule
`default_nettype wire
